/* sleep_gate_pkg.sv */
// constants, types and helpers for the sleep-mode unit clock gating block
// assumes: 12-bit register offsets within the system control window
package sleep_gate_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int UNITS = 7;
   localparam int UNIT_IDX_W = 3;
   localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;
   localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h104;
   localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h114;
   localparam logic [ADDR_W-1:0] DEEP_GATE_OFS = 12'h124;
   localparam logic [ADDR_W-1:0] RUN_CFG_OFS = 12'h1F0;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h1F4;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h1F8;
   // gating bit positions
   localparam int ASYNC0_BIT = 0;
   localparam int ASYNC1_BIT = 1;
   localparam int SYNC0_BIT = 4;
   localparam int GPC0_BIT = 16;
   localparam int GPC1_BIT = 17;
   localparam int GPC2_BIT = 18;
   localparam int COMPARATOR_ZERO_GATE_BIT = 24;
   localparam int AUTO_GATE_BIT = 0;
   localparam logic [DATA_W-1:0] GATE_IMPL_MASK = 32'h0107_0013;
   localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CFG_IMPL_MASK = 32'h0000_0001;
   localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
   // interrupt event positions
   localparam int EV_FAULT_BIT = 0;
   localparam int EV_MODE_BIT = 1;
   localparam int EV_W = 2;
   localparam logic [EV_W-1:0] EV_RESET = 2'h0;
   localparam logic [UNITS-1:0] UNITS_OFF = 7'h00;

   typedef enum logic [1:0] {
      PM_RUN = 2'h0,
      PM_SLEEP = 2'h1,
      PM_DEEP = 2'h3
   } power_mode_t;

   // unit order: async0, async1, sync0, gpc0, gpc1, gpc2, comparator_zero_gate
   function automatic logic [UNITS-1:0] gate_to_units(input logic [DATA_W-1:0] r);
      gate_to_units = {r[COMPARATOR_ZERO_GATE_BIT], r[GPC2_BIT], r[GPC1_BIT], r[GPC0_BIT],
                       r[SYNC0_BIT], r[ASYNC1_BIT], r[ASYNC0_BIT]};
   endfunction : gate_to_units
endpackage : sleep_gate_pkg

/* gate_if.sv */
// carrier between the gating core, its mode selector and its access checker
// assumes: one clock, all members driven by the modules on the modports
`timescale 1ns/10ps
`default_nettype none
interface gate_if;
   import sleep_gate_pkg::*;
   logic [UNITS-1:0] active_en;
   logic [UNITS-1:0] applied_en;
   logic acc_valid;
   logic [UNIT_IDX_W-1:0] acc_unit;
   logic acc_fault;
   logic acc_ok;
   modport sel (output active_en);
   modport chk (input applied_en, input acc_valid, input acc_unit,
                output acc_fault, output acc_ok);
   modport core (input active_en, output applied_en, output acc_valid,
                 output acc_unit, input acc_fault, input acc_ok);
endinterface : gate_if
`default_nettype wire

/* gate_select.sv */
// picks which gating register drives the unit clocks
// assumes: register values already masked to implemented bits
`timescale 1ns/10ps
`default_nettype none
module gate_select
   import sleep_gate_pkg::*;
(
   input wire logic [DATA_W-1:0] run_gate,
   input wire logic [DATA_W-1:0] sleep_gate,
   input wire logic [DATA_W-1:0] deep_gate,
   input wire logic auto_gate,
   input wire power_mode_t mode,
   gate_if.sel gif
);
   wire logic [UNITS-1:0] run_units;
   wire logic [UNITS-1:0] sleep_units;
   wire logic [UNITS-1:0] deep_units;
   wire logic use_sleep;
   wire logic use_deep;
   assign run_units = gate_to_units(run_gate);
   assign sleep_units = gate_to_units(sleep_gate);
   assign deep_units = gate_to_units(deep_gate);
   // without auto gating the run settings stay in force while asleep
   assign use_sleep = auto_gate && (mode == PM_SLEEP);
   assign use_deep = auto_gate && (mode == PM_DEEP);
   assign gif.active_en = use_deep ? deep_units :
                          use_sleep ? sleep_units : run_units;
endmodule : gate_select
`default_nettype wire

/* access_check.sv */
// flags processor accesses that reach a unit with its clock stopped
// assumes: acc_unit is an index into the unit order of the package
`timescale 1ns/10ps
`default_nettype none
module access_check
   import sleep_gate_pkg::*;
(
   gate_if.chk gif
);
   wire logic unit_known;
   wire logic unit_clocked;
   assign unit_known = (gif.acc_unit < UNIT_IDX_W'(UNITS));
   // an index past the last unit has no clock at all and faults too
   assign unit_clocked = unit_known && gif.applied_en[gif.acc_unit];
   assign gif.acc_fault = gif.acc_valid && !unit_clocked;
   assign gif.acc_ok = gif.acc_valid && unit_clocked;
endmodule : access_check
`default_nettype wire

/* sleep_mode_clock_gating.sv */
// unit clock gating registers for run, sleep and deep sleep, with bus fault on access
// assumes: one clock, register port strobes one cycle long, power requests synchronous
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sleep_mode_clock_gating
   import sleep_gate_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic wake_req,
   input wire logic acc_valid,
   input wire logic [UNIT_IDX_W-1:0] acc_unit,
   output logic acc_ok,
   output logic acc_fault,
   output logic [UNITS-1:0] unit_clock_enable,
   output logic [UNITS-1:0] unit_disable,
   output logic [1:0] power_mode,
   output logic irq
);
   gate_if gif ();

   logic [DATA_W-1:0] run_unit_clock_gate_reg;
   logic [DATA_W-1:0] sleep_unit_clock_gate_reg;
   logic [DATA_W-1:0] deep_sleep_unit_clock_gate_reg;
   logic [DATA_W-1:0] run_clock_configuration_reg;
   logic [EV_W-1:0] irq_status_reg;
   logic [EV_W-1:0] irq_mask_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [UNITS-1:0] unit_en_reg;
   logic [UNITS-1:0] unit_dis_reg;
   logic acc_ok_reg;
   logic acc_fault_reg;
   logic irq_reg;
   power_mode_t mode_reg;
   power_mode_t mode_next;

   // address decode
   wire logic sel_run;
   wire logic sel_sleep;
   wire logic sel_deep;
   wire logic sel_cfg;
   wire logic sel_status;
   wire logic sel_mask;
   assign sel_run = (addr == RUN_GATE_OFS);
   assign sel_sleep = (addr == SLEEP_GATE_OFS);
   assign sel_deep = (addr == DEEP_GATE_OFS);
   assign sel_cfg = (addr == RUN_CFG_OFS);
   assign sel_status = (addr == IRQ_STATUS_OFS);
   assign sel_mask = (addr == IRQ_MASK_OFS);

   wire logic wr_run;
   wire logic wr_sleep;
   wire logic wr_deep;
   wire logic wr_cfg;
   wire logic wr_status;
   wire logic wr_mask;
   assign wr_run = wr && sel_run;
   assign wr_sleep = wr && sel_sleep;
   assign wr_deep = wr && sel_deep;
   assign wr_cfg = wr && sel_cfg;
   assign wr_status = wr && sel_status;
   assign wr_mask = wr && sel_mask;

   // only implemented bits are stored, so reserved ones can never read back
   wire logic [DATA_W-1:0] gate_wdata;
   assign gate_wdata = wdata & GATE_IMPL_MASK;

   wire logic auto_gate;
   assign auto_gate = run_clock_configuration_reg[AUTO_GATE_BIT];

   // gating registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_unit_clock_gate_reg <= GATE_RESET;
      end else if (wr_run) begin
         run_unit_clock_gate_reg <= gate_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep_unit_clock_gate_reg <= GATE_RESET;
      end else if (wr_sleep) begin
         sleep_unit_clock_gate_reg <= gate_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         deep_sleep_unit_clock_gate_reg <= GATE_RESET;
      end else if (wr_deep) begin
         deep_sleep_unit_clock_gate_reg <= gate_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_clock_configuration_reg <= CFG_RESET;
      end else if (wr_cfg) begin
         run_clock_configuration_reg <= wdata & CFG_IMPL_MASK;
      end
   end

   // power state: run -> sleep -> deep sleep follows a gray path
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         PM_RUN: begin
            if (deep_sleep_req) begin
               mode_next = PM_DEEP;
            end else if (sleep_req) begin
               mode_next = PM_SLEEP;
            end
         end
         PM_SLEEP: begin
            if (wake_req) begin
               mode_next = PM_RUN;
            end else if (deep_sleep_req) begin
               mode_next = PM_DEEP;
            end
         end
         PM_DEEP: begin
            if (wake_req) begin
               mode_next = PM_RUN;
            end
         end
         default: begin
            mode_next = PM_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= PM_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // selection of the register in force
   gate_select u_select (
      .run_gate(run_unit_clock_gate_reg),
      .sleep_gate(sleep_unit_clock_gate_reg),
      .deep_gate(deep_sleep_unit_clock_gate_reg),
      .auto_gate(auto_gate),
      .mode(mode_reg),
      .gif(gif.sel)
   );

   // enables lag the register write by one cycle; the checker uses what units see
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unit_en_reg <= UNITS_OFF;
         unit_dis_reg <= ~UNITS_OFF;
      end else begin
         unit_en_reg <= gif.active_en;
         unit_dis_reg <= ~gif.active_en;
      end
   end

   assign gif.applied_en = unit_en_reg;
   assign gif.acc_valid = acc_valid;
   assign gif.acc_unit = acc_unit;

   access_check u_check (
      .gif(gif.chk)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_ok_reg <= 1'b0;
         acc_fault_reg <= 1'b0;
      end else begin
         acc_ok_reg <= gif.acc_ok;
         acc_fault_reg <= gif.acc_fault;
      end
   end

   // sticky events; a new event beats a write-one clear in the same cycle
   wire logic [EV_W-1:0] ev_set;
   wire logic [EV_W-1:0] ev_clr;
   wire logic [EV_W-1:0] irq_status_next;
   assign ev_set[EV_FAULT_BIT] = gif.acc_fault;
   assign ev_set[EV_MODE_BIT] = (mode_next != mode_reg);
   assign ev_clr = wr_status ? wdata[EV_W-1:0] : EV_RESET;
   assign irq_status_next = (irq_status_reg & ~ev_clr) | ev_set;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_status_reg <= EV_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_reg <= EV_RESET;
      end else if (wr_mask) begin
         irq_mask_reg <= wdata[EV_W-1:0];
      end
   end

   // irq is registered from the next status, so it changes in the same cycle as the status
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_next & irq_mask_reg);
      end
   end

   // read mux; unmapped offsets read zero
   wire logic [DATA_W-1:0] rd_mux;
   assign rd_mux = sel_run ? run_unit_clock_gate_reg :
                   sel_sleep ? sleep_unit_clock_gate_reg :
                   sel_deep ? deep_sleep_unit_clock_gate_reg :
                   sel_cfg ? run_clock_configuration_reg :
                   sel_status ? {{(DATA_W-EV_W){1'b0}}, irq_status_reg} :
                   sel_mask ? {{(DATA_W-EV_W){1'b0}}, irq_mask_reg} :
                   GATE_RESET;

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= GATE_RESET;
      end else begin
         rdata_reg <= rd ? rd_mux : GATE_RESET;
      end
   end

   assign rdata = rdata_reg;
   assign acc_ok = acc_ok_reg;
   assign acc_fault = acc_fault_reg;
   assign unit_clock_enable = unit_en_reg;
   assign unit_disable = unit_dis_reg;
   assign power_mode = mode_reg;
   assign irq = irq_reg;
endmodule : sleep_mode_clock_gating
`default_nettype wire

/* sleep_gate_assertions.sv */
// port assertions for the sleep-mode unit clock gating block
// assumes: bound to sleep_mode_clock_gating; one clock, rstn low resets
`timescale 1ns/10ps
`default_nettype none
module sleep_gate_assertions
   import sleep_gate_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic acc_valid,
   input wire logic [UNIT_IDX_W-1:0] acc_unit,
   input wire logic acc_ok,
   input wire logic acc_fault,
   input wire logic [UNITS-1:0] unit_clock_enable,
   input wire logic [UNITS-1:0] unit_disable,
   input wire logic [1:0] power_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   function automatic logic [6:0] units_of(input logic [31:0] w);
      units_of = {w[24], w[18], w[17], w[16], w[4], w[1], w[0]};
   endfunction : units_of
   AST_DISABLE_INV: assert property (unit_disable == ~unit_clock_enable)
      else $error("unit disable is not the inverse of enable");
   AST_RESET: assert property ($rose(rstn) |-> unit_clock_enable == 7'h00 && power_mode == 2'h0)
      else $error("units clocked or mode set after reset");
   AST_FAULT: assert property (acc_valid && (acc_unit == 3'h7 || !unit_clock_enable[acc_unit])
      |=> acc_fault && !acc_ok) else $error("no fault on access to stopped unit");
   AST_OK: assert property (acc_valid && acc_unit != 3'h7 && unit_clock_enable[acc_unit]
      |=> acc_ok && !acc_fault) else $error("clocked unit access not completed");
   AST_QUIET: assert property (!acc_valid |=> !acc_ok && !acc_fault)
      else $error("access answer without access");
   AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
      else $error("read data outside answer cycle");
   AST_RESERVED: assert property (rd && addr == SLEEP_GATE_OFS |=>
      (rdata & ~GATE_IMPL_MASK) == 32'h0) else $error("reserved bits read nonzero");
   AST_READBACK: assert property (wr && addr == SLEEP_GATE_OFS ##1 rd && addr == SLEEP_GATE_OFS
      |=> rdata == ($past(wdata, 2) & GATE_IMPL_MASK)) else $error("sleep gate readback wrong");
   AST_RUN_FOLLOW: assert property (power_mode == 2'h0 && wr && addr == RUN_GATE_OFS
      && !sleep_req && !deep_sleep_req ##1 !sleep_req && !deep_sleep_req && !wr
      |=> unit_clock_enable == units_of($past(wdata, 2))) else $error("run gate not applied");
   cover property (acc_valid ##1 acc_fault);
   cover property (power_mode == 2'h1 && unit_clock_enable != 7'h00);
   cover property (power_mode == 2'h3);
endmodule : sleep_gate_assertions
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the sleep-mode unit clock gating block
// assumes: register port with one-cycle strobes, read data one cycle later
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import sleep_gate_pkg::*;
;
   logic clk, rstn, wr, rd, sleep_req, deep_sleep_req, wake_req, acc_valid;
   logic acc_ok, acc_fault, irq;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [UNIT_IDX_W-1:0] acc_unit;
   logic [UNITS-1:0] unit_clock_enable, unit_disable;
   logic [1:0] power_mode;
   int n_errors, samples_checked, cycles;
   int bits[7] = '{0, 1, 4, 16, 17, 18, 24};
   sleep_mode_clock_gating sleep_mode_clock_gating_i (.clk(clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req), .wake_req(wake_req), .acc_valid(acc_valid),
      .acc_unit(acc_unit), .acc_ok(acc_ok), .acc_fault(acc_fault),
      .unit_clock_enable(unit_clock_enable), .unit_disable(unit_disable),
      .power_mode(power_mode), .irq(irq));
   always #5 clk = ~clk;
   // hang guard, well above the fewer than a hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // tasks start just after an edge so strobes run back to back
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask : rd_chk
   task automatic units_chk(input logic [6:0] exp);
      @(posedge clk);
      #1 chk("enable", {25'h0, exp}, {25'h0, unit_clock_enable});
      chk("disable", {25'h0, ~exp}, {25'h0, unit_disable});
   endtask : units_chk
   task automatic access(input logic [2:0] u, input logic ok);
      acc_unit <= u;
      acc_valid <= 1'b1;
      @(posedge clk);
      acc_valid <= 1'b0;
      #1 chk("acc_ok", {31'h0, ok}, {31'h0, acc_ok});
      chk("acc_fault", {31'h0, !ok}, {31'h0, acc_fault});
   endtask : access
   task automatic mode(input logic [1:0] k, input logic [6:0] exp);
      sleep_req <= (k == 2'h1);
      deep_sleep_req <= (k == 2'h3);
      wake_req <= (k == 2'h0);
      @(posedge clk);
      {sleep_req, deep_sleep_req, wake_req} <= 3'h0;
      units_chk(exp);
      chk("mode", {30'h0, k}, {30'h0, power_mode});
   endtask : mode
   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge clk);
      #1 chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask : irq_chk
   initial begin
      {clk, rstn, wr, rd, sleep_req, deep_sleep_req, wake_req, acc_valid} = 8'h00;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      acc_unit = 3'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd_chk(SLEEP_GATE_OFS, 32'h0000_0000);
      units_chk(7'h00);
      $display("test reset done");
      wr_reg(SLEEP_GATE_OFS, 32'hFFFF_FFFF);
      rd_chk(SLEEP_GATE_OFS, 32'h0107_0013);
      foreach (bits[i]) begin
         wr_reg(SLEEP_GATE_OFS, 32'h1 << bits[i]);
         rd_chk(SLEEP_GATE_OFS, 32'h1 << bits[i]);
      end
      wr_reg(12'h118, 32'hFFFF_FFFF);
      rd_chk(12'h118, 32'h0000_0000);
      $display("test register access done");
      wr_reg(RUN_GATE_OFS, 32'h0001_0011);
      units_chk(7'h0D);
      for (int u = 0; u < 8; u++) access(u[2:0], u == 0 || u == 2 || u == 3);
      $display("test run gating done");
      wr_reg(SLEEP_GATE_OFS, 32'h0106_0002);
      wr_reg(DEEP_GATE_OFS, 32'h0000_0001);
      mode(2'h1, 7'h0D);
      mode(2'h0, 7'h0D);
      wr_reg(RUN_CFG_OFS, 32'h0000_0001);
      mode(2'h1, 7'h72);
      access(3'h6, 1'b1);
      access(3'h0, 1'b0);
      mode(2'h3, 7'h01);
      mode(2'h0, 7'h0D);
      $display("test mode gating done");
      wr_reg(IRQ_MASK_OFS, 32'h0000_0003);
      irq_chk(1'b1);
      wr_reg(IRQ_STATUS_OFS, 32'h0000_0003);
      irq_chk(1'b0);
      access(3'h7, 1'b0);
      irq_chk(1'b1);
      wr_reg(IRQ_MASK_OFS, 32'h0000_0000);
      irq_chk(1'b0);
      $display("test interrupt done");
      wr_reg(SLEEP_GATE_OFS, 32'h0107_0013);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd_chk(SLEEP_GATE_OFS, 32'h0000_0000);
      units_chk(7'h00);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : tb_top
bind sleep_mode_clock_gating sleep_gate_assertions sleep_gate_assertions_i (.clk(clk),
   .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .acc_valid(acc_valid),
   .acc_unit(acc_unit), .acc_ok(acc_ok), .acc_fault(acc_fault),
   .unit_clock_enable(unit_clock_enable), .unit_disable(unit_disable), .power_mode(power_mode));
`default_nettype wire
